// >>> dv/mws_proc_model.sv
// Purpose: Processor side that owns the retention bit and asks for MCU entry.
// Assumes: Bench pulses req for one cycle.
// Notes: Retention bit settles a cycle before the entry pulse.
module mws_proc_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic req,
    input wire logic ret_in,
    output logic enter_mcu_only_seq,
    output logic ddr_retention_trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    logic arm_q;
    // Set retention bit, then pulse entry one cycle later
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            arm_q <= 1'b0;
            enter_mcu_only_seq <= 1'b0;
            ddr_retention_trigger <= 1'b0;
        end else begin
            arm_q <= req;
            enter_mcu_only_seq <= arm_q;
            if (req)
                ddr_retention_trigger <= ret_in;
        end
    end
endmodule

// >>> dv/mws_seq_test.sv
// Purpose: Self-checking bench for the warm-reset and MCU-entry sequencer.
// Assumes: One tick per cycle and one tick per delay step.
// Notes: Offsets are checked within a small cycle window.
module mws_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mws_pkg::*;
    localparam int SL = 6;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} mws_row_t;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic watchdog_fail = 1'b0;
    logic mcu_error_monitor_fault = 1'b0;
    logic req = 1'b0;
    logic ret_in = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic enter_mcu_only_seq, ddr_retention_trigger, mcu_reset_out, soc_reset_out;
    logic error_driver_enable, ddr_supply_enable, ddr_core_rail, mcu_analog_en;
    logic mcu_io_rail_en, vreg_reload, mcu_only_state, safe_recovery, seq_busy;
    logic [3:0] soc_rail_en;
    logic [3:0] gp_out;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n_rel = 0;
    int t0, tf, t_sup, t_core, t_busy;
    mws_row_t rows[6] = '{'{1'b0, ADDR_MISC, 8'h00, 8'h03}, '{1'b0, ADDR_EDRV, 8'h00, 8'h00},
        '{1'b0, ADDR_RECOV, 8'h00, 8'h20}, '{1'b0, ADDR_DELAY, 8'h00, 8'h00},
        '{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b1, ADDR_DELAY, 8'h03, 8'h03}};

    mws_seq #(.TICK_CYC(1), .DLY_UNIT_US(1), .IS_PRIMARY(1'b1)) mws_seq_i (
        .core_clk(core_clk), .rst_b(rst_b), .watchdog_fail(watchdog_fail),
        .mcu_error_monitor_fault(mcu_error_monitor_fault), .enter_mcu_only_seq(enter_mcu_only_seq),
        .ddr_retention_trigger(ddr_retention_trigger), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mcu_reset_out(mcu_reset_out), .soc_reset_out(soc_reset_out),
        .error_driver_enable(error_driver_enable), .soc_rail_en(soc_rail_en),
        .ddr_supply_enable(ddr_supply_enable), .ddr_core_rail(ddr_core_rail),
        .mcu_analog_en(mcu_analog_en), .mcu_io_rail_en(mcu_io_rail_en), .vreg_reload(vreg_reload),
        .gp_out(gp_out), .mcu_only_state(mcu_only_state), .safe_recovery(safe_recovery),
        .seq_busy(seq_busy));

    mws_proc_model mws_proc_model_i (
        .core_clk(core_clk), .rst_b(rst_b), .req(req), .ret_in(ret_in),
        .enter_mcu_only_seq(enter_mcu_only_seq), .ddr_retention_trigger(ddr_retention_trigger));

    // Clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // Cycle count on the falling edge, so change stamps never race it
    always @(negedge core_clk) cyc <= cyc + 1;
    always @(ddr_supply_enable) t_sup = cyc;
    always @(ddr_core_rail) t_core = cyc;
    always @(negedge seq_busy) t_busy = cyc;
    always @(posedge core_clk) if (vreg_reload === 1'b1) n_rel <= n_rel + 1;

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic ck(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        idle(1);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        idle(1);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
        idle(1);
        reg_rd = 1'b1;
        reg_addr = a;
        idle(1);
        reg_rd = 1'b0;
        ck(reg_rdata === e, m);
    endtask

    // Bounded wait for a level; running out ends the run
    task automatic wt(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++)
            idle(1);
        if (s !== v) begin
            errors++;
            $display("[FAIL] %0t wait ran out", $time);
            finish_test();
        end
    endtask

    task automatic entry(input logic ret);
        idle(1);
        ret_in = ret;
        req = 1'b1;
        t0 = cyc;
        idle(1);
        req = 1'b0;
        idle(4);
    endtask

    // Main sequence
    initial begin
        idle(3);
        ck(mcu_reset_out === 1'b1 && soc_reset_out === 1'b1 && seq_busy === 1'b0, "reset levels");
        rst_b = 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e, "register row");
        end
        wr(ADDR_GP, 8'h05);
        ck(gp_out === 4'h5, "gp write");
        watchdog_fail = 1'b1;
        idle(20);
        ck(mcu_reset_out === 1'b1 && seq_busy === 1'b0, "fault outside MCU-only");
        watchdog_fail = 1'b0;
        // Entry with retention low
        wr(ADDR_MISC, 8'h06);
        wr(ADDR_EDRV, 8'h08);
        entry(1'b0);
        rd(ADDR_MISC, 8'h18, "entry misc write");
        ck(soc_reset_out === 1'b0 && mcu_reset_out === 1'b0, "entry start resets");
        wt(seq_busy, 1'b0, 20000);
        ck(t_sup - t0 >= 500 && t_sup - t0 <= 500 + SL, "supply off time");
        ck(t_core - t0 >= 3000 && t_core - t0 <= 3000 + SL, "core off time");
        ck(ddr_supply_enable === 1'b0 && ddr_core_rail === 1'b0, "ddr rails off");
        ck(soc_rail_en === 4'h0 && mcu_analog_en === 1'b1 && mcu_io_rail_en === 1'b1, "rails");
        ck(t_busy - t0 >= 16203 && t_busy - t0 <= 16203 + SL, "entry end time");
        ck(mcu_reset_out === 1'b1 && mcu_only_state === 1'b1, "entry end state");
        rd(ADDR_EDRV, 8'h00, "entry end driver bits");
        rd(ADDR_MISC, 8'h19, "entry end misc");
        // Entry with retention high
        entry(1'b1);
        wt(seq_busy, 1'b0, 20000);
        ck(t_sup - t0 >= 4700 && t_sup - t0 <= 4700 + SL, "supply on time");
        ck(t_core - t0 >= 5200 && t_core - t0 <= 5200 + SL, "core on time");
        ck(ddr_supply_enable === 1'b1 && ddr_core_rail === 1'b1, "ddr rails kept");
        // Warm reset from MCU-only
        wr(ADDR_EDRV, 8'h01);
        ck(error_driver_enable === 1'b1, "processor sets driver");
        n_rel = 0;
        watchdog_fail = 1'b1;
        wt(mcu_reset_out, 1'b0, 10);
        tf = cyc;
        ck(error_driver_enable === 1'b0 && seq_busy === 1'b1, "warm start");
        wr(ADDR_GP, 8'h0A);
        rd(ADDR_EDRV, 8'h09, "force low set");
        rd(ADDR_MISC, 8'h18, "mcu reset cleared");
        ck(gp_out === 4'h5 && n_rel == 1, "gp held, one reload");
        wt(mcu_reset_out, 1'b1, 2100);
        ck(cyc - tf >= 2000 && cyc - tf <= 2000 + SL, "warm release time");
        ck(mcu_only_state === 1'b1 && mcu_io_rail_en === 1'b1, "state and rails kept");
        ck(error_driver_enable === 1'b1, "driver free again");
        rd(ADDR_RECOV, 8'h21, "count incremented");
        rd(ADDR_EDRV, 8'h01, "force low cleared");
        watchdog_fail = 1'b0;
        // Count past threshold holds safe recovery
        wr(ADDR_RECOV, 8'h01);
        mcu_error_monitor_fault = 1'b1;
        wt(mcu_reset_out, 1'b0, 10);
        idle(2100);
        ck(safe_recovery === 1'b1 && mcu_reset_out === 1'b0 && seq_busy === 1'b0, "safe hold");
        rd(ADDR_RECOV, 8'h02, "count past threshold");
        entry(1'b1);
        ck(seq_busy === 1'b0, "entry refused when safe");
        // Reset in mid-run
        rst_b = 1'b0;
        idle(1);
        ck(mcu_reset_out === 1'b1 && safe_recovery === 1'b0, "second reset");
        idle(2);
        // Release with the fault pin still high: its edge must be refused
        rst_b = 1'b1;
        rd(ADDR_RECOV, RECOV_RST_VAL, "recovery after second reset");
        idle(4);
        ck(seq_busy === 1'b0 && mcu_reset_out === 1'b1 && mcu_only_state === 1'b0, "fault after reset");
        rd(ADDR_MISC, MISC_RST_VAL, "misc after second reset");
        finish_test();
    end
endmodule

// >>> src/mws_pkg.sv
// Purpose: Constants for the MCU warm-reset and MCU-entry sequencer.
// Assumes: 50 MHz core clock, one-microsecond sequencer timebase.
// Notes: Masked writes keep every bit whose mask bit is one.
package mws_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_HZ = 1_000_000;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    // Register offsets
    localparam logic [7:0] ADDR_MISC = 8'h81;
    localparam logic [7:0] ADDR_EDRV = 8'h82;
    localparam logic [7:0] ADDR_RECOV = 8'hA5;
    localparam logic [7:0] ADDR_DELAY = 8'hCD;
    localparam logic [7:0] ADDR_GP = 8'hFF;
    // Field positions
    localparam int MISC_MCU_RST = 0;
    localparam int MISC_SOC_RST = 1;
    localparam int MISC_LPM = 2;
    localparam int EDRV_DRV_EN = 0;
    localparam int EDRV_FORCE_LOW = 3;
    localparam int EDRV_SPMI_LP = 4;
    // Masked-write immediates
    localparam logic [7:0] WARM_EDRV_DATA = 8'h08;
    localparam logic [7:0] WARM_EDRV_MASK = 8'hF7;
    localparam logic [7:0] WARM_MISC_DATA = 8'h00;
    localparam logic [7:0] WARM_MISC_MASK = 8'hFE;
    localparam logic [7:0] ENTRY_MISC_DATA = 8'h18;
    localparam logic [7:0] ENTRY_MISC_MASK_PRI = 8'hE1;
    localparam logic [7:0] ENTRY_MISC_MASK_SEC = 8'hE3;
    localparam logic [7:0] ENTRY_EDRV_DATA = 8'h00;
    localparam logic [7:0] ENTRY_EDRV_MASK = 8'hEF;
    localparam logic [7:0] END_EDRV_DATA = 8'h00;
    localparam logic [7:0] END_EDRV_MASK = 8'hE7;
    localparam logic [7:0] END_MISC_DATA = 8'h01;
    localparam logic [7:0] END_MISC_MASK = 8'hFE;
    // Reset values
    localparam logic [7:0] MISC_RST_VAL = 8'h03;
    localparam logic [7:0] EDRV_RST_VAL = 8'h00;
    localparam logic [7:0] RECOV_RST_VAL = 8'h20;
    localparam logic [7:0] DELAY_RST_VAL = 8'h00;
    localparam logic [3:0] GP_RST_VAL = 4'h0;
    // Sequence offsets in microseconds
    localparam int T_WARM_REL_US = 2000;
    localparam int T_SOC0_US = 500;
    localparam int T_SOC1_US = 2500;
    localparam int T_SOC2_US = 3000;
    localparam int T_SOC3_US = 3500;
    localparam int T_DDR_SUP_OFF_US = 500;
    localparam int T_DDR_CORE_OFF_US = 3000;
    localparam int T_DDR_SUP_ON_US = 4700;
    localparam int T_MCU_ANA_US = 5200;
    localparam int T_MCU_IO_US = 7200;
    localparam int T_ENTRY_END_US = 16200;
    localparam int DELAY_UNIT_US = 1000;
    localparam int US_W = 18;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WARM = 2'b01,
        SEQ_ENTRY = 2'b10,
        SEQ_DELAY = 2'b11
    } mws_seq_t;
endpackage

// >>> src/mws_seq.sv
// Purpose: MCU warm-reset and MCU-only entry sequencer with its control registers.
// Assumes: Register port driven by the serial-interface logic on core_clk.
// Notes: Fault inputs arrive from pins and are synchronised before use.
module mws_seq #(
    parameter int TICK_CYC = mws_pkg::TICK_CYCLES,
    parameter int DLY_UNIT_US = mws_pkg::DELAY_UNIT_US,
    parameter bit IS_PRIMARY = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic watchdog_fail,
    input wire logic mcu_error_monitor_fault,
    input wire logic enter_mcu_only_seq,
    input wire logic ddr_retention_trigger,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic mcu_reset_out,
    output logic soc_reset_out,
    output logic error_driver_enable,
    output logic [3:0] soc_rail_en,
    output logic ddr_supply_enable,
    output logic ddr_core_rail,
    output logic mcu_analog_en,
    output logic mcu_io_rail_en,
    output logic vreg_reload,
    output logic [3:0] gp_out,
    output logic mcu_only_state,
    output logic safe_recovery,
    output logic seq_busy
);
    import mws_pkg::*;

    function automatic logic [7:0] mwr(input logic [7:0] old, input logic [7:0] data, input logic [7:0] mask);
        mwr = (old & mask) | (data & ~mask);
    endfunction

    logic [2:0] wd_sync_q;
    logic [2:0] esm_sync_q;
    logic fault_evt;
    logic [7:0] tick_cnt_q;
    logic tick;
    mws_seq_t seq_q;
    logic [US_W-1:0] us_q;
    logic [US_W-1:0] wait_us_q;
    logic ret_q;
    logic mcu_only_q;
    logic safe_q;
    logic [7:0] misc_q;
    logic [7:0] edrv_q;
    logic [7:0] recov_q;
    logic [7:0] delay_q;
    logic [3:0] recov_next;
    logic warm_go;
    logic entry_go;
    logic warm_done;
    logic entry_mid;
    logic delay_done;
    logic host_wr_misc;
    logic host_wr_edrv;
    logic host_wr_gp;

    // Two-flop synchronisers plus one edge stage
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_sync_q <= 3'h0;
            esm_sync_q <= 3'h0;
        end else begin
            wd_sync_q <= {wd_sync_q[1:0], watchdog_fail};
            esm_sync_q <= {esm_sync_q[1:0], mcu_error_monitor_fault};
        end
    end
    assign fault_evt = (wd_sync_q[1] & ~wd_sync_q[2]) | (esm_sync_q[1] & ~esm_sync_q[2]);

    // Free-running microsecond tick
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_q <= 8'h00;
        end else if (tick) begin
            tick_cnt_q <= 8'h00;
        end else begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
        end
    end
    assign tick = (tick_cnt_q == 8'(TICK_CYC - 1));

    // Acceptance and step decode
    assign warm_go = fault_evt && seq_q == SEQ_IDLE && mcu_only_q && !safe_q;
    assign entry_go = enter_mcu_only_seq && !warm_go && seq_q == SEQ_IDLE && !safe_q;
    assign recov_next = recov_q[3:0] + 4'h1;
    assign warm_done = seq_q == SEQ_WARM && tick && us_q == US_W'(T_WARM_REL_US);
    assign entry_mid = seq_q == SEQ_ENTRY && tick && us_q == US_W'(T_ENTRY_END_US);
    assign delay_done = seq_q == SEQ_DELAY && (us_q >= wait_us_q);
    assign host_wr_misc = reg_wr && reg_addr == ADDR_MISC;
    assign host_wr_edrv = reg_wr && reg_addr == ADDR_EDRV;
    assign host_wr_gp = reg_wr && reg_addr == ADDR_GP;

    // Sequence state and microsecond offset counter
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            seq_q <= SEQ_IDLE;
            us_q <= '0;
            wait_us_q <= '0;
            ret_q <= 1'b0;
        end else begin
            unique case (seq_q)
                SEQ_IDLE: begin
                    us_q <= '0;
                    if (warm_go && recov_next <= recov_q[7:4]) begin
                        seq_q <= SEQ_WARM;
                    end else if (entry_go) begin
                        seq_q <= SEQ_ENTRY;
                        ret_q <= ddr_retention_trigger;
                    end
                end
                SEQ_WARM: begin
                    if (warm_done) begin
                        seq_q <= SEQ_IDLE;
                    end else if (tick) begin
                        us_q <= us_q + US_W'(1);
                    end
                end
                SEQ_ENTRY: begin
                    if (entry_mid) begin
                        seq_q <= SEQ_DELAY;
                        us_q <= '0;
                        wait_us_q <= US_W'(delay_q) * US_W'(DLY_UNIT_US);
                    end else if (tick) begin
                        us_q <= us_q + US_W'(1);
                    end
                end
                SEQ_DELAY: begin
                    if (delay_done) begin
                        seq_q <= SEQ_IDLE;
                    end else if (tick) begin
                        us_q <= us_q + US_W'(1);
                    end
                end
            endcase
        end
    end

    // Power state and safe recovery latch
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mcu_only_q <= 1'b0;
            safe_q <= 1'b0;
        end else begin
            if (warm_go && recov_next > recov_q[7:4]) begin
                safe_q <= 1'b1;
            end
            if (delay_done) begin
                mcu_only_q <= 1'b1;
            end
        end
    end

    // Misc control register: sequencer writes win over host writes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            misc_q <= MISC_RST_VAL;
        end else if (warm_go) begin
            misc_q <= mwr(misc_q, WARM_MISC_DATA, WARM_MISC_MASK);
        end else if (warm_done) begin
            misc_q[MISC_MCU_RST] <= 1'b1;
        end else if (entry_go) begin
            misc_q <= mwr(misc_q, ENTRY_MISC_DATA, IS_PRIMARY ? ENTRY_MISC_MASK_PRI : ENTRY_MISC_MASK_SEC);
        end else if (delay_done && IS_PRIMARY) begin
            misc_q <= mwr(misc_q, END_MISC_DATA, END_MISC_MASK);
        end else if (host_wr_misc) begin
            misc_q <= reg_wdata;
        end
    end

    // Driver status register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            edrv_q <= EDRV_RST_VAL;
        end else if (warm_go) begin
            edrv_q <= mwr(edrv_q, WARM_EDRV_DATA, WARM_EDRV_MASK);
        end else if (warm_done) begin
            edrv_q[EDRV_FORCE_LOW] <= 1'b0;
        end else if (entry_go) begin
            edrv_q <= mwr(edrv_q, ENTRY_EDRV_DATA, ENTRY_EDRV_MASK);
        end else if (delay_done && IS_PRIMARY) begin
            edrv_q <= mwr(edrv_q, END_EDRV_DATA, END_EDRV_MASK);
        end else if (host_wr_edrv) begin
            edrv_q <= reg_wdata;
        end
    end

    // Recovery counter (low nibble) and threshold (high nibble)
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            recov_q <= RECOV_RST_VAL;
        end else if (warm_go) begin
            recov_q <= {recov_q[7:4], recov_next};
        end else if (reg_wr && reg_addr == ADDR_RECOV) begin
            recov_q <= reg_wdata;
        end
    end

    // Delay register and general-purpose outputs (host owned)
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            delay_q <= DELAY_RST_VAL;
            gp_out <= GP_RST_VAL;
        end else begin
            if (reg_wr && reg_addr == ADDR_DELAY) begin
                delay_q <= reg_wdata;
            end
            if (host_wr_gp && seq_q != SEQ_WARM) begin
                gp_out <= reg_wdata[3:0];
            end
        end
    end

    // Rail enables stepped at their offsets
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            soc_rail_en <= 4'hF;
            ddr_supply_enable <= 1'b1;
            ddr_core_rail <= 1'b1;
            mcu_analog_en <= 1'b1;
            mcu_io_rail_en <= 1'b1;
        end else if (seq_q == SEQ_ENTRY && tick) begin
            if (us_q == US_W'(T_SOC0_US)) soc_rail_en[0] <= 1'b0;
            if (us_q == US_W'(T_SOC1_US)) soc_rail_en[1] <= 1'b0;
            if (us_q == US_W'(T_SOC2_US)) soc_rail_en[2] <= 1'b0;
            if (us_q == US_W'(T_SOC3_US)) soc_rail_en[3] <= 1'b0;
            if (!ret_q && us_q == US_W'(T_DDR_SUP_OFF_US)) ddr_supply_enable <= 1'b0;
            if (!ret_q && us_q == US_W'(T_DDR_CORE_OFF_US)) ddr_core_rail <= 1'b0;
            if (ret_q && us_q == US_W'(T_DDR_SUP_ON_US)) ddr_supply_enable <= 1'b1;
            if (ret_q && us_q == US_W'(T_MCU_ANA_US)) ddr_core_rail <= 1'b1;
            if (us_q == US_W'(T_MCU_ANA_US)) mcu_analog_en <= 1'b1;
            if (us_q == US_W'(T_MCU_IO_US)) mcu_io_rail_en <= 1'b1;
        end
    end

    // Voltage reload pulse, no enable change
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vreg_reload <= 1'b0;
        end else begin
            vreg_reload <= warm_go;
        end
    end

    // Register read port
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_MISC: reg_rdata <= misc_q;
                ADDR_EDRV: reg_rdata <= edrv_q;
                ADDR_RECOV: reg_rdata <= recov_q;
                ADDR_DELAY: reg_rdata <= delay_q;
                default: reg_rdata <= {4'h0, safe_q, mcu_only_q, seq_q};
            endcase
        end
    end

    // Pin outputs
    assign mcu_reset_out = misc_q[MISC_MCU_RST];
    assign soc_reset_out = misc_q[MISC_SOC_RST];
    assign error_driver_enable = edrv_q[EDRV_DRV_EN] & ~edrv_q[EDRV_FORCE_LOW];
    assign mcu_only_state = mcu_only_q;
    assign safe_recovery = safe_q;
    assign seq_busy = seq_q != SEQ_IDLE;

    property p_warm_start;
        @(posedge core_clk) disable iff (!rst_b)
        warm_go |=> !mcu_reset_out && edrv_q[EDRV_FORCE_LOW] && !error_driver_enable;
    endproperty
    a_warm_start: assert property (p_warm_start) else $error("warm start outputs wrong");

    property p_recov_inc;
        @(posedge core_clk) disable iff (!rst_b)
        warm_go |=> recov_q[3:0] == $past(recov_q[3:0]) + 4'h1;
    endproperty
    a_recov_inc: assert property (p_recov_inc) else $error("recovery count not incremented");

    property p_warm_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (seq_q == SEQ_WARM && !warm_done) |=> !mcu_reset_out;
    endproperty
    a_warm_hold: assert property (p_warm_hold) else $error("reset released early");

    property p_warm_end;
        @(posedge core_clk) disable iff (!rst_b)
        warm_done |=> mcu_reset_out && !edrv_q[EDRV_FORCE_LOW] && seq_q == SEQ_IDLE && mcu_only_q;
    endproperty
    a_warm_end: assert property (p_warm_end) else $error("warm end wrong");

    property p_warm_state;
        @(posedge core_clk) disable iff (!rst_b)
        warm_go |-> mcu_only_q;
    endproperty
    a_warm_state: assert property (p_warm_state) else $error("warm accepted outside MCU-only");

    property p_safe;
        @(posedge core_clk) disable iff (!rst_b)
        safe_q |=> safe_q && seq_q == SEQ_IDLE;
    endproperty
    a_safe: assert property (p_safe) else $error("left safe recovery");

    property p_entry_start;
        @(posedge core_clk) disable iff (!rst_b)
        entry_go |=> misc_q[4:3] == 2'b11 && !misc_q[MISC_LPM] && !edrv_q[EDRV_SPMI_LP];
    endproperty
    a_entry_start: assert property (p_entry_start) else $error("entry start writes wrong");

    property p_ddr_off;
        @(posedge core_clk) disable iff (!rst_b)
        (seq_q == SEQ_ENTRY && tick && !ret_q && us_q == US_W'(T_DDR_SUP_OFF_US)) |=> !ddr_supply_enable;
    endproperty
    a_ddr_off: assert property (p_ddr_off) else $error("DDR supply not dropped");

    property p_ddr_keep;
        @(posedge core_clk) disable iff (!rst_b)
        (seq_q == SEQ_ENTRY && ret_q && ddr_core_rail) |=> ddr_core_rail;
    endproperty
    a_ddr_keep: assert property (p_ddr_keep) else $error("DDR core dropped in retention");

    property p_gp_stable;
        @(posedge core_clk) disable iff (!rst_b)
        seq_q == SEQ_WARM |=> $stable(gp_out);
    endproperty
    a_gp_stable: assert property (p_gp_stable) else $error("general outputs changed in warm reset");

    property p_soc_off;
        @(posedge core_clk) disable iff (!rst_b)
        (seq_q == SEQ_ENTRY && tick && us_q == US_W'(T_SOC3_US)) |=> soc_rail_en == 4'h0;
    endproperty
    a_soc_off: assert property (p_soc_off) else $error("SoC rails still on after last step");

    property p_entry_end;
        @(posedge core_clk) disable iff (!rst_b)
        (delay_done && IS_PRIMARY) |=>
            mcu_reset_out && !edrv_q[EDRV_FORCE_LOW] && !edrv_q[EDRV_SPMI_LP] && mcu_only_q;
    endproperty
    a_entry_end: assert property (p_entry_end) else $error("entry end writes wrong");
endmodule
